// >>> include/temp_i2c_if.sv
// Two-wire link between host and sensor, with pull-up resolution.
interface temp_i2c_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // A released line floats high through its pull-up.
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n,
    input  scl,
    input  sda
  );
  modport device (
    output dev_sda_o,
    output dev_sda_oe_n,
    input  scl,
    input  sda
  );
endinterface

// >>> include/temp_i2c_pkg.sv
// Constants shared by the temperature sensor link ends.
// Overview of operation
// - Mode high bit selects continuous conversions.
// - After each continuous conversion, standby for the rate period less the conversion time.
// - Host starts only when both lines idle.
// - Host clocks nine pulses per byte.
// - Data changes only while clock is low.
// - Start is data falling with clock high.
// - Repeated start precedes the read command.
// - Stop is data rising with clock high.
// - Direction bit low writes, high reads.
// - Device acknowledges written bytes by pulling low.
// - Host acknowledge low requests the second byte.
// - Final read slot released as not-acknowledge.
// - Host drives write data, device only acknowledges.
// - Device drives read data, host only acknowledges.
// - Reading only the upper byte is allowed.
// - Pulses shorter than 20 ns are ignored.
// - Rate codes give 0.25, 1, 4, 16 Hz.
// - Mode 00 shuts down; 01 runs once.
// - Temperature read gives sixteen bits, upper first.
package temp_i2c_pkg;
  localparam int clk_period_ns = 8;
  localparam int filt_time_ns  = 20;
  localparam int filt_cycles   =
    (filt_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int cycles_per_us = 1000 / clk_period_ns;
  localparam int conv_time_us  = 7800;
  localparam int conv_cycles   = conv_time_us * cycles_per_us;
  localparam int period_0_us   = 4000000;
  localparam int period_1_us   = 1000000;
  localparam int period_2_us   = 250000;
  localparam int period_3_us   = 62500;
  localparam int period_0_cycles = period_0_us * cycles_per_us;
  localparam int period_1_cycles = period_1_us * cycles_per_us;
  localparam int period_2_cycles = period_2_us * cycles_per_us;
  localparam int period_3_cycles = period_3_us * cycles_per_us;
  localparam int scl_quarter_cycles = 8;
  localparam logic [6:0] dev_address = 7'h4a;
  localparam logic [7:0] ptr_temp    = 8'h00;
  localparam logic [7:0] ptr_config  = 8'h01;
  localparam int mode_select_low_bit  = 0;
  localparam int mode_select_high_bit = 1;
  localparam int rate_select_low_bit  = 2;
  localparam int rate_select_high_bit = 3;
  localparam logic [7:0] cfg_reset   = 8'h06;
  localparam logic [4:0] reg_control = 5'h00;
  localparam logic [4:0] reg_pointer = 5'h04;
  localparam logic [4:0] reg_wdata   = 5'h08;
  localparam logic [4:0] reg_status  = 5'h0c;
  localparam logic [4:0] reg_rdata   = 5'h10;
  localparam logic [4:0] reg_target  = 5'h14;
  localparam int ctl_go_bit   = 0;
  localparam int ctl_read_bit = 1;
  localparam int ctl_two_bit  = 2;
  localparam int st_busy_bit  = 0;
  localparam int st_nack_bit  = 1;
endpackage

// >>> verification/temp_link_asserts.sv
// Link checks across the host and sensor ends.
module temp_link_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] rises;
  logic [3:0] next_rises;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Rises since the last start; the ninth carries the address ack.
  always_comb
  begin
    next_rises = rises;
    if (scl && scl_q && sda_q && !sda)
      next_rises = 4'h0;
    else if (scl && !scl_q && rises != 4'hf)
      next_rises = rises + 4'h1;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rises <= 4'hf;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      rises <= next_rises;
    end
  end
  sequence start_s;
    $fell(sda) && scl;
  endsequence
  sequence stop_s;
    $rose(sda) && scl;
  endsequence
  dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data moved with clock high");
  clk_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  clk_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  idle_start_a: assert property (
    start_s |-> $past(sda, 4) && $past(scl, 4))
    else $error("start without idle lines");
  start_quiet_a: assert property (start_s |=> dev_sda_oe_n [*8])
    else $error("device drives after start");
  stop_idle_a: assert property (stop_s |=> (sda && scl) [*8])
    else $error("bus not idle after stop");
  one_driver_a: assert property (
    scl && !scl_q |-> host_sda_oe_n || dev_sda_oe_n)
    else $error("both ends drive data");
  addr_ack_a: assert property (
    scl && !scl_q && rises == 4'h8 |-> !dev_sda_oe_n)
    else $error("address not acknowledged");
endmodule // temp_link_asserts

// >>> verification/temp_sensor_i2c_register_access_tb_top.sv
// Bench joining host and sensor ends over the two-wire link.
module temp_sensor_i2c_register_access_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int per [4] = '{100, 80, 60, 40};
  logic        clk;
  logic        reset_n;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [11:0] temp_sample;
  logic [11:0] temp_result;
  logic [7:0]  config_value;
  logic        conv_active;
  logic [31:0] rdv;
  logic [31:0] exp_q[$];
  int          num_errors;
  int          num_checks;
  int          seed;
  time         t0;
  temp_i2c_if link ();
  temp_sensor_dev #(.conv_cycles(20), .period_0_cycles(per[0]),
    .period_1_cycles(per[1]), .period_2_cycles(per[2]),
    .period_3_cycles(per[3])) temp_sensor_dev_inst (.clk(clk),
    .reset_n(reset_n), .bus(link), .temp_sample(temp_sample),
    .temp_result(temp_result), .conv_active(conv_active),
    .config_value(config_value));
  temp_i2c_host temp_i2c_host_inst (.clk(clk), .reset_n(reset_n),
    .bus(link), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest));
  temp_link_asserts temp_link_asserts_inst (.clk(clk), .reset_n(reset_n),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
    .scl(link.scl), .sda(link.sda));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // Entered just after a rising edge; the extra edge keeps strobes apart.
  task automatic bus(input logic [4:0] a, input logic rd, logic [31:0] d);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    do
      @(posedge clk);
    while (waitrequest);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b1, 32'h0);
  endtask
  task automatic run(input logic [7:0] p, input logic [31:0] c);
    int n;
    bus(temp_i2c_pkg::reg_pointer, 1'b0, {24'h0, p});
    bus(temp_i2c_pkg::reg_control, 1'b0, c);
    n = 0;
    do
    begin
      bus(temp_i2c_pkg::reg_status, 1'b1, 32'h0);
      n++;
    end
    while (rdv[0] && n < 3000);
    chk("status", 32'h0, rdv);
  endtask
  task automatic cfg(input logic [7:0] v);
    bus(temp_i2c_pkg::reg_wdata, 1'b0, {24'h0, v});
    run(temp_i2c_pkg::ptr_config, 32'h0000_0005);
  endtask
  task automatic get(input logic [7:0] p, input logic two, logic [31:0] e);
    run(p, {29'h0, two, 2'b11});
    rd(temp_i2c_pkg::reg_rdata, e);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
    if (read && !waitrequest && exp_q.size() > 0)
      chk("readdata", exp_q.pop_front(), readdata);
  initial
  begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial
  begin
    seed = 32'hfbdd;
    num_errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    {address, read, write, writedata} = '0;
    temp_sample = 12'($random(seed));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(temp_i2c_pkg::reg_target, 32'h0000_004a);
    rd(5'h18, 32'h0);
    get(temp_i2c_pkg::ptr_config, 1'b0, 32'h0000_0006);
    $display("test reset done");
    repeat (2)
    begin
      temp_sample <= 12'($random(seed));
      @(posedge clk);
      get(temp_i2c_pkg::ptr_temp, 1'b1, {16'h0, temp_sample, 4'h0});
      get(temp_i2c_pkg::ptr_temp, 1'b0, {24'h0, temp_sample[11:4]});
      chk("result", {20'h0, temp_sample}, {20'h0, temp_result});
    end
    $display("test temperature done");
    for (int c = 0; c < 4; c++)
    begin
      cfg({4'h0, c[1:0], 2'b10});
      repeat (2) @(posedge conv_active);
      t0 = $time;
      @(posedge conv_active);
      chk("period", per[c], 32'(($time - t0) / 8));
    end
    $display("test rates done");
    cfg(8'h00);
    repeat (40) @(posedge clk);
    chk("shutdown", 32'h0, {31'h0, conv_active});
    fork
      cfg(8'h01);
      begin
        @(posedge conv_active);
        @(negedge clk);
        chk("oneshot", 32'h1, {30'h0, config_value[1:0]});
      end
    join
    get(temp_i2c_pkg::ptr_config, 1'b0, 32'h0);
    $display("test oneshot done");
    end_sim();
  end
endmodule // temp_sensor_i2c_register_access_tb_top

// >>> verilog/temp_i2c_host.sv
// Host end: Avalon-MM command registers driving the two-wire link.
module temp_i2c_host (
  input  wire logic        clk,
  input  wire logic        reset_n,
  temp_i2c_if.host         bus,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest
);
  localparam int qw = $clog2(temp_i2c_pkg::scl_quarter_cycles);
  typedef enum logic [2:0] {
    h_idle, h_wait_free, h_start, h_tx, h_rx, h_rstart, h_stop
  } host_state_t;

  logic [1:0]  sync_a;
  logic [1:0]  sync_b;
  host_state_t hstate;
  host_state_t next_hstate;
  logic [qw-1:0] qcnt;
  logic [qw-1:0] next_qcnt;
  logic [1:0]  q;
  logic [1:0]  next_q;
  logic [3:0]  bidx;
  logic [3:0]  next_bidx;
  logic [2:0]  seq;
  logic [2:0]  next_seq;
  logic [7:0]  tx;
  logic [7:0]  next_tx;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic        nack;
  logic        next_nack;
  logic        scl_low;
  logic        next_scl_low;
  logic        sda_low;
  logic        next_sda_low;
  logic        tick;
  logic        sda_s;
  logic        served;
  logic        next_served;
  logic [31:0] next_readdata;
  logic [7:0]  pointer;
  logic [7:0]  next_pointer;
  logic [7:0]  wdata;
  logic [7:0]  next_wdata;
  logic [6:0]  target;
  logic [6:0]  next_target;
  logic        op_read;
  logic        next_op_read;
  logic        op_two;
  logic        next_op_two;
  logic        take_wr;
  logic        start_req;

  assign sda_s = sync_b[0];
  assign tick  = (qcnt == qw'(temp_i2c_pkg::scl_quarter_cycles - 1));

  always_comb
  begin
    next_hstate = hstate;
    next_qcnt   = tick ? '0 : qcnt + 1'b1;
    next_q      = q;
    next_bidx   = bidx;
    next_seq    = seq;
    next_tx     = tx;
    next_rdata  = rdata;
    next_nack   = nack;
    case (hstate)
      h_idle:
      begin
        next_qcnt = '0;
        if (start_req)
        begin
          next_hstate = h_wait_free;
          next_nack   = 1'b0;
          next_rdata  = 16'h0000;
        end
      end
      h_wait_free:
      begin
        if (!(sync_b[1] && sda_s))
          next_qcnt = '0;
        else if (tick)
        begin
          next_hstate = h_start;
          next_q      = 2'h0;
        end
      end
      default:
      begin
        if (tick)
        begin
          next_q = q + 2'h1;
          if (q == 2'h3)
          begin
            next_bidx = 4'h0;
            case (hstate)
              h_start, h_rstart:
              begin
                next_hstate = h_tx;
                next_seq    = (hstate == h_start) ? 3'h0 : 3'h3;
                next_tx     = {target, hstate == h_rstart};
              end
              h_tx:
              begin
                if (bidx != 4'h8)
                begin
                  next_bidx = bidx + 4'h1;
                  next_tx   = {tx[6:0], 1'b0};
                end
                else if (sda_s)
                begin
                  next_nack   = 1'b1;
                  next_hstate = h_stop;
                end
                else if (seq == 3'h0)
                begin
                  next_seq = 3'h1;
                  next_tx  = pointer;
                end
                else if (seq == 3'h1 && op_read)
                  next_hstate = h_rstart;
                else if (seq == 3'h1 && op_two)
                begin
                  next_seq = 3'h2;
                  next_tx  = wdata;
                end
                else if (seq == 3'h3)
                begin
                  next_hstate = h_rx;
                  next_seq    = 3'h4;
                end
                else
                  next_hstate = h_stop;
              end
              h_rx:
              begin
                if (bidx != 4'h8)
                begin
                  next_bidx  = bidx + 4'h1;
                  next_rdata = {rdata[14:0], sda_s};
                end
                else if (seq == 3'h4 && op_two)
                  next_seq = 3'h5;
                else
                  next_hstate = h_stop;
              end
              default:
                next_hstate = h_idle;
            endcase
          end
        end
      end
    endcase
    // Bit data moves one quarter after the clock falls; start, restart and stop edges move it with clock high.
    next_scl_low = 1'b0;
    next_sda_low = 1'b0;
    if (next_hstate == h_start)
      next_sda_low = (next_q != 2'h0) | sda_low;
    else if (next_hstate != h_idle && next_hstate != h_wait_free)
    begin
      next_scl_low = (next_q < 2'h2);
      if (next_q == 2'h0)
        next_sda_low = sda_low;
      else if (next_hstate == h_tx)
        next_sda_low = (next_bidx != 4'h8) & ~next_tx[7];
      else if (next_hstate == h_rx)
        next_sda_low = (next_bidx == 4'h8) & (next_seq == 3'h4)
                       & op_two;
      else if (next_hstate == h_rstart)
        next_sda_low = (next_q == 2'h3);
      else
        next_sda_low = (next_q != 2'h3);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_a  <= 2'h3;
      sync_b  <= 2'h3;
      hstate  <= h_idle;
      qcnt    <= '0;
      q       <= 2'h0;
      bidx    <= 4'h0;
      seq     <= 3'h0;
      tx      <= 8'h00;
      rdata   <= 16'h0000;
      nack    <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end
    else
    begin
      sync_a  <= {bus.scl, bus.sda};
      sync_b  <= sync_a;
      hstate  <= next_hstate;
      qcnt    <= next_qcnt;
      q       <= next_q;
      bidx    <= next_bidx;
      seq     <= next_seq;
      tx      <= next_tx;
      rdata   <= next_rdata;
      nack    <= next_nack;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
    end
  end

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_scl_oe_n = ~scl_low;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = ~sda_low;

  // Every access is answered in its second cycle.
  assign waitrequest = (read | write) & ~served;
  assign take_wr     = write & served;
  assign start_req   = take_wr & (address == temp_i2c_pkg::reg_control)
                       & writedata[temp_i2c_pkg::ctl_go_bit]
                       & (hstate == h_idle);

  always_comb
  begin
    next_served   = (read | write) & ~served;
    next_readdata = readdata;
    next_pointer  = pointer;
    next_wdata    = wdata;
    next_target   = target;
    next_op_read  = op_read;
    next_op_two   = op_two;
    if (start_req)
    begin
      next_op_read = writedata[temp_i2c_pkg::ctl_read_bit];
      next_op_two  = writedata[temp_i2c_pkg::ctl_two_bit];
    end
    if (take_wr)
    begin
      if (address == temp_i2c_pkg::reg_pointer)
        next_pointer = writedata[7:0];
      else if (address == temp_i2c_pkg::reg_wdata)
        next_wdata = writedata[7:0];
      else if (address == temp_i2c_pkg::reg_target)
        next_target = writedata[6:0];
    end
    if (read && !served)
    begin
      next_readdata = 32'h0000_0000;
      if (address == temp_i2c_pkg::reg_control)
        next_readdata[2:1] = {op_two, op_read};
      else if (address == temp_i2c_pkg::reg_pointer)
        next_readdata[7:0] = pointer;
      else if (address == temp_i2c_pkg::reg_wdata)
        next_readdata[7:0] = wdata;
      else if (address == temp_i2c_pkg::reg_status)
        next_readdata[1:0] = {nack, hstate != h_idle};
      else if (address == temp_i2c_pkg::reg_rdata)
        next_readdata[15:0] = rdata;
      else if (address == temp_i2c_pkg::reg_target)
        next_readdata[6:0] = target;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      served   <= 1'b0;
      readdata <= 32'h0000_0000;
      pointer  <= temp_i2c_pkg::ptr_temp;
      wdata    <= 8'h00;
      target   <= temp_i2c_pkg::dev_address;
      op_read  <= 1'b0;
      op_two   <= 1'b0;
    end
    else
    begin
      served   <= next_served;
      readdata <= next_readdata;
      pointer  <= next_pointer;
      wdata    <= next_wdata;
      target   <= next_target;
      op_read  <= next_op_read;
      op_two   <= next_op_two;
    end
  end
endmodule // temp_i2c_host

// >>> verilog/temp_sensor_dev.sv
// Sensor end: two-wire target, register file and conversion scheduler.
module temp_sensor_dev #(
  parameter int conv_cycles     = temp_i2c_pkg::conv_cycles,
  parameter int period_0_cycles = temp_i2c_pkg::period_0_cycles,
  parameter int period_1_cycles = temp_i2c_pkg::period_1_cycles,
  parameter int period_2_cycles = temp_i2c_pkg::period_2_cycles,
  parameter int period_3_cycles = temp_i2c_pkg::period_3_cycles
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  temp_i2c_if.device       bus,
  input  wire logic [11:0] temp_sample,
  output logic      [11:0] temp_result,
  output logic             conv_active,
  output logic      [7:0]  config_value
);
  typedef enum logic [2:0] {
    link_idle, link_addr, link_addr_ack, link_wr, link_wr_ack,
    link_rd, link_rd_ack
  } link_state_t;
  typedef enum logic [1:0] {
    sched_off, sched_conv, sched_standby
  } sched_state_t;

  // Index 1 carries the clock line, index 0 the data line.
  logic [1:0]   sync_a;
  logic [1:0]   sync_b;
  logic [1:0]   flt;
  logic [1:0]   next_flt;
  logic [1:0]   flt_prev;
  logic [1:0]   fcnt [2];
  logic [1:0]   next_fcnt [2];
  logic         scl_rise;
  logic         scl_fall;
  logic         start_seen;
  logic         stop_seen;

  link_state_t  lstate;
  link_state_t  next_lstate;
  logic [3:0]   bitcnt;
  logic [3:0]   next_bitcnt;
  logic [7:0]   shreg;
  logic [7:0]   next_shreg;
  logic         rw;
  logic         next_rw;
  logic         wcount;
  logic         next_wcount;
  logic [7:0]   pointer;
  logic [7:0]   next_pointer;
  logic         rd_idx;
  logic         next_rd_idx;
  logic         drive;
  logic         next_drive;
  logic [11:0]  snap;
  logic [11:0]  next_snap;
  logic [7:0]   tx;
  logic         cfg_wr;
  logic [7:0]   cfg_wdata;

  sched_state_t sstate;
  sched_state_t next_sstate;
  logic [31:0]  timer;
  logic [31:0]  next_timer;
  logic [7:0]   cfg;
  logic [7:0]   next_cfg;
  logic [11:0]  next_result;
  logic         mode_high;
  logic [1:0]   mode;
  logic [1:0]   rate;

  // Byte served on a read; the pointer was set by an earlier write.
  function automatic logic [7:0] rd_byte(input logic [7:0] ptr,
                                         input logic idx,
                                         input logic [11:0] t,
                                         input logic [7:0] c);
    if (ptr == temp_i2c_pkg::ptr_temp)
      return idx ? {t[3:0], 4'h0} : t[11:4];
    else if (ptr == temp_i2c_pkg::ptr_config)
      return c;
    else
      return 8'h00;
  endfunction

  function automatic logic [31:0] standby_len(input logic [1:0] rate);
    int p;
    case (rate)
      2'h0: p = period_0_cycles;
      2'h1: p = period_1_cycles;
      2'h2: p = period_2_cycles;
      default: p = period_3_cycles;
    endcase
    return 32'(p - conv_cycles);
  endfunction

  // A level must hold for the filter time before it is believed.
  always_comb
  begin
    next_flt = flt;
    for (int i = 0; i < 2; i++)
    begin
      next_fcnt[i] = 2'h0;
      if (sync_b[i] != flt[i])
      begin
        if (fcnt[i] == 2'(temp_i2c_pkg::filt_cycles - 1))
          next_flt[i] = sync_b[i];
        else
          next_fcnt[i] = fcnt[i] + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_a   <= 2'h3;
      sync_b   <= 2'h3;
      flt      <= 2'h3;
      flt_prev <= 2'h3;
      fcnt[0]  <= 2'h0;
      fcnt[1]  <= 2'h0;
    end
    else
    begin
      sync_a   <= {bus.scl, bus.sda};
      sync_b   <= sync_a;
      flt      <= next_flt;
      flt_prev <= flt;
      fcnt     <= next_fcnt;
    end
  end

  assign scl_rise   = flt[1] & ~flt_prev[1];
  assign scl_fall   = ~flt[1] & flt_prev[1];
  assign start_seen = flt[1] & flt_prev[1] & flt_prev[0] & ~flt[0];
  assign stop_seen  = flt[1] & flt_prev[1] & ~flt_prev[0] & flt[0];
  assign tx         = rd_byte(pointer, rd_idx, snap, cfg);

  always_comb
  begin
    next_lstate  = lstate;
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_rw      = rw;
    next_wcount  = wcount;
    next_pointer = pointer;
    next_rd_idx  = rd_idx;
    next_drive   = drive;
    next_snap    = snap;
    cfg_wr       = 1'b0;
    cfg_wdata    = shreg;
    if (start_seen)
    begin
      next_lstate = link_addr;
      next_bitcnt = 4'h0;
      next_wcount = 1'b0;
      next_drive  = 1'b0;
    end
    else if (stop_seen)
    begin
      next_lstate = link_idle;
      next_drive  = 1'b0;
    end
    else
    begin
      case (lstate)
        link_addr, link_wr:
        begin
          if (scl_rise)
          begin
            next_shreg  = {shreg[6:0], flt[0]};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == 4'h8)
          begin
            next_bitcnt = 4'h0;
            if (lstate == link_wr)
            begin
              next_drive  = 1'b1;
              next_lstate = link_wr_ack;
              next_wcount = 1'b1;
              if (!wcount)
                next_pointer = shreg;
              else if (pointer == temp_i2c_pkg::ptr_config)
                cfg_wr = 1'b1;
            end
            else if (shreg[7:1] == temp_i2c_pkg::dev_address)
            begin
              next_drive  = 1'b1;
              next_rw     = shreg[0];
              next_lstate = link_addr_ack;
              next_rd_idx = 1'b0;
              next_snap   = temp_result;
            end
            else
              next_lstate = link_idle;
          end
        end
        link_addr_ack, link_wr_ack:
        begin
          if (scl_fall)
          begin
            if (lstate == link_addr_ack && rw)
            begin
              next_lstate = link_rd;
              next_drive  = ~tx[7];
              next_shreg  = {tx[6:0], 1'b0};
              next_rd_idx = ~rd_idx;
            end
            else
            begin
              next_lstate = link_wr;
              next_drive  = 1'b0;
            end
          end
        end
        link_rd:
        begin
          if (scl_rise)
            next_bitcnt = bitcnt + 4'h1;
          else if (scl_fall)
          begin
            if (bitcnt == 4'h8)
            begin
              next_drive  = 1'b0;
              next_lstate = link_rd_ack;
            end
            else
            begin
              next_drive = ~shreg[7];
              next_shreg = {shreg[6:0], 1'b0};
            end
          end
        end
        link_rd_ack:
        begin
          if (scl_rise)
          begin
            if (flt[0])
              next_lstate = link_idle;
            else
              next_bitcnt = 4'h0;
          end
          else if (scl_fall && bitcnt == 4'h0)
          begin
            next_lstate = link_rd;
            next_drive  = ~tx[7];
            next_shreg  = {tx[6:0], 1'b0};
            next_rd_idx = ~rd_idx;
          end
        end
        default:
          next_drive = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lstate  <= link_idle;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      rw      <= 1'b0;
      wcount  <= 1'b0;
      pointer <= temp_i2c_pkg::ptr_temp;
      rd_idx  <= 1'b0;
      drive   <= 1'b0;
      snap    <= 12'h000;
    end
    else
    begin
      lstate  <= next_lstate;
      bitcnt  <= next_bitcnt;
      shreg   <= next_shreg;
      rw      <= next_rw;
      wcount  <= next_wcount;
      pointer <= next_pointer;
      rd_idx  <= next_rd_idx;
      drive   <= next_drive;
      snap    <= next_snap;
    end
  end

  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = ~drive;

  assign mode_high = cfg[temp_i2c_pkg::mode_select_high_bit];
  assign mode      = {mode_high, cfg[temp_i2c_pkg::mode_select_low_bit]};
  assign rate      = {cfg[temp_i2c_pkg::rate_select_high_bit],
                      cfg[temp_i2c_pkg::rate_select_low_bit]};

  // A bus write landing in the cycle the one-shot ends is kept.
  always_comb
  begin
    next_sstate = sstate;
    next_timer  = timer;
    next_cfg    = cfg;
    next_result = temp_result;
    case (sstate)
      sched_off:
      begin
        if (mode != 2'h0)
        begin
          next_sstate = sched_conv;
          next_timer  = 32'h0000_0000;
        end
      end
      sched_conv:
      begin
        next_timer = timer + 32'h0000_0001;
        if (timer == 32'(conv_cycles - 1))
        begin
          next_result = temp_sample;
          next_timer  = 32'h0000_0000;
          if (mode_high)
            next_sstate = sched_standby;
          else
          begin
            next_sstate = sched_off;
            next_cfg[temp_i2c_pkg::mode_select_low_bit] = 1'b0;
          end
        end
      end
      default:
      begin
        next_timer = timer + 32'h0000_0001;
        if (!mode_high)
          next_sstate = sched_off;
        else if (timer >= standby_len(rate) - 32'h0000_0001)
        begin
          next_sstate = sched_conv;
          next_timer  = 32'h0000_0000;
        end
      end
    endcase
    if (cfg_wr)
      next_cfg = cfg_wdata;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sstate      <= sched_conv;
      timer       <= 32'h0000_0000;
      cfg         <= temp_i2c_pkg::cfg_reset;
      temp_result <= 12'h000;
    end
    else
    begin
      sstate      <= next_sstate;
      timer       <= next_timer;
      cfg         <= next_cfg;
      temp_result <= next_result;
    end
  end

  assign conv_active  = (sstate == sched_conv);
  assign config_value = cfg;
endmodule // temp_sensor_dev
